// ### rtl/rucs_pkg.sv
/*
  Package for the remote update configuration sequencer: register map,
  field positions, reset values, cause codes, states and the bus carriers.
  Assumes a single 100 MHz clock domain and an APB register bus.
*/
// Notes on behaviour
// - At power-up in remote mode, load the image at page zero.
// - Factory image is default; in remote mode any application load failure falls back to it.
// - Watchdog expiry in an application records status and reloads factory image.
// - Watchdog held disabled while the factory image is loaded.
// - Application load failure writes its cause into the status register.
// - After a recorded failure, factory loads alone; factory reads the cause.
// - A successful application load enters user mode running that application.
// - Page selection allows at most seven distinct application pages.
// - Local mode loads its single application directly, no factory first.
package rucs_pkg;

  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STAT = 12'h004;
  localparam logic [11:0] OFF_WDOG = 12'h008;
  localparam logic [11:0] OFF_KICK = 12'h00c;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h010;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h014;

  localparam int PAGE_W = 3;
  localparam logic [2:0] PAGE_FACTORY = 3'h0;
  localparam logic [2:0] PAGE_LOCAL = 3'h1;

  // Control register fields
  localparam int CTRL_PAGE_LSB = 0;
  localparam int CTRL_WD_EN_BIT = 4;
  localparam int CTRL_RECONF_BIT = 8;

  // Status register fields
  localparam int STAT_CAUSE_LSB = 0;
  localparam int STAT_PAGE_LSB = 4;
  localparam int STAT_FACT_BIT = 8;
  localparam int STAT_USER_BIT = 9;

  localparam int CAUSE_W = 2;
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_LOAD_ERR = 2'h1;
  localparam logic [1:0] CAUSE_WDOG = 2'h2;
  localparam logic [1:0] CAUSE_REQ = 2'h3;

  // Interrupt event bits
  localparam int IRQ_W = 3;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_ERR_BIT = 1;
  localparam int IRQ_WDOG_BIT = 2;

  localparam logic [31:0] WDOG_RESET = 32'h0000_ffff;
  localparam logic [31:0] APB_UNMAPPED = 32'h0000_0000;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_LOAD = 5'h02,
    ST_USER = 5'h04,
    ST_FAIL = 5'h08,
    ST_WAIT = 5'h10
  } rucs_state_e;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } rucs_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } rucs_apb_rsp_s;

  typedef struct packed {
    logic start;
    logic [PAGE_W-1:0] page;
  } rucs_load_req_s;

endpackage

// ### rtl/rucs_top.sv
/*
  Configuration-page sequencer. Drives a load request toward the paged
  configuration memory, tracks factory and application images, runs the
  user watchdog and records reconfiguration causes.
  Assumes the memory loader answers with done or error pins from another
  domain; those pass two flip-flops here.
*/
`timescale 1ns/1ps
module rucs_top (
  // Clock, reset, enable
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Straps and requests
  input wire logic LOCAL_MODE,
  input wire logic RECONF_REQ,
  // Configuration memory loader
  output rucs_pkg::rucs_load_req_s LOAD_REQ,
  input wire logic LOAD_DONE,
  input wire logic LOAD_ERR,
  // APB
  input wire rucs_pkg::rucs_apb_req_s APB_REQ,
  output rucs_pkg::rucs_apb_rsp_s APB_RSP,
  // Status
  output logic USER_MODE,
  output logic IRQ
);

  rucs_pkg::rucs_state_e state_reg, state_next;
  logic [rucs_pkg::PAGE_W-1:0] page_reg, page_next;
  logic [rucs_pkg::PAGE_W-1:0] cur_reg, cur_next;
  logic [rucs_pkg::PAGE_W-1:0] nxt_reg, nxt_next;
  logic wd_en_reg, wd_en_next;
  logic [31:0] wd_lim_reg, wd_lim_next;
  logic [31:0] wd_cnt_reg, wd_cnt_next;
  logic [rucs_pkg::CAUSE_W-1:0] cause_reg, cause_next;
  logic [rucs_pkg::IRQ_W-1:0] ist_reg, ist_next;
  logic [rucs_pkg::IRQ_W-1:0] imask_reg, imask_next;
  logic [31:0] rdata_reg, rdata_next;
  logic start_reg, start_next;
  logic local_reg, local_next;
  logic [1:0] done_sync_reg, err_sync_reg, req_sync_reg, mode_sync_reg;
  logic done_s, err_s, req_s, req_prev_reg;
  logic rd_seen_reg;
  logic wr, rd, factory, wd_kick, wd_exp;
  logic [rucs_pkg::IRQ_W-1:0] ev;

  function automatic logic [rucs_pkg::PAGE_W-1:0] clip_page(input logic [31:0] d);
    logic [rucs_pkg::PAGE_W-1:0] p;
    p = d[rucs_pkg::CTRL_PAGE_LSB +: rucs_pkg::PAGE_W];
    // Page zero holds the factory image; only seven application pages exist
    clip_page = (p == rucs_pkg::PAGE_FACTORY) ? cur_reg : p;
  endfunction

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      done_sync_reg <= 2'h0;
      err_sync_reg <= 2'h0;
      req_sync_reg <= 2'h0;
      req_prev_reg <= 1'b0;
    end else if (CLK_EN) begin
      done_sync_reg <= {done_sync_reg[0], LOAD_DONE};
      err_sync_reg <= {err_sync_reg[0], LOAD_ERR};
      req_sync_reg <= {req_sync_reg[0], RECONF_REQ};
      req_prev_reg <= req_sync_reg[1];
    end
  end

  // Strap synchroniser has no reset so the mode is settled when reset ends;
  // reset must therefore span at least two enabled edges
  always_ff @(posedge MCLK) begin
    if (CLK_EN) begin
      mode_sync_reg <= {mode_sync_reg[0], LOCAL_MODE};
    end
  end
  assign done_s = done_sync_reg[1];
  assign err_s = err_sync_reg[1];
  assign req_s = req_sync_reg[1] & ~req_prev_reg;

  // Writes act only at the ready edge, so each transfer writes exactly once
  assign wr = APB_REQ.psel & APB_REQ.penable & APB_REQ.pwrite & rd_seen_reg;
  assign rd = APB_REQ.psel & APB_REQ.penable & ~APB_REQ.pwrite;
  assign factory = (cur_reg == rucs_pkg::PAGE_FACTORY) & ~local_reg;
  assign wd_kick = wr & (APB_REQ.paddr == rucs_pkg::OFF_KICK);
  assign wd_exp = (state_reg == rucs_pkg::ST_USER) & wd_en_reg & ~factory
                  & (wd_cnt_reg >= wd_lim_reg);

  always_comb begin
    state_next = state_reg;
    page_next = page_reg;
    cur_next = cur_reg;
    nxt_next = nxt_reg;
    wd_en_next = wd_en_reg;
    wd_lim_next = wd_lim_reg;
    wd_cnt_next = wd_cnt_reg;
    cause_next = cause_reg;
    start_next = 1'b0;
    local_next = local_reg;
    ev = '0;
    // Control and watchdog limit writes apply only while the factory image is current
    if (wr && APB_REQ.paddr == rucs_pkg::OFF_CTRL && factory) begin
      nxt_next = clip_page(APB_REQ.pwdata);
      wd_en_next = APB_REQ.pwdata[rucs_pkg::CTRL_WD_EN_BIT];
    end
    if (wr && APB_REQ.paddr == rucs_pkg::OFF_WDOG && factory) begin
      wd_lim_next = APB_REQ.pwdata;
    end
    case (state_reg)
      rucs_pkg::ST_IDLE: begin
        // Strap taken after reset release, never inside the reset branch
        local_next = mode_sync_reg[1];
        page_next = mode_sync_reg[1] ? rucs_pkg::PAGE_LOCAL : rucs_pkg::PAGE_FACTORY;
        start_next = 1'b1;
        state_next = rucs_pkg::ST_LOAD;
      end
      rucs_pkg::ST_LOAD: begin
        if (err_s) begin
          state_next = rucs_pkg::ST_FAIL;
        end else if (done_s) begin
          cur_next = page_reg;
          wd_cnt_next = '0;
          ev[rucs_pkg::IRQ_DONE_BIT] = 1'b1;
          state_next = rucs_pkg::ST_USER;
        end
      end
      rucs_pkg::ST_USER: begin
        if (wd_exp) begin
          cause_next = rucs_pkg::CAUSE_WDOG;
          ev[rucs_pkg::IRQ_WDOG_BIT] = 1'b1;
          page_next = rucs_pkg::PAGE_FACTORY;
          start_next = 1'b1;
          state_next = rucs_pkg::ST_WAIT;
        end else if (req_s || (wr && APB_REQ.paddr == rucs_pkg::OFF_CTRL
                     && APB_REQ.pwdata[rucs_pkg::CTRL_RECONF_BIT])) begin
          // Factory loads the chosen page from nxt_next; an application reloads its fallback page
          if (factory) begin
            page_next = nxt_next;
          end else begin
            cause_next = rucs_pkg::CAUSE_REQ;
            page_next = local_reg ? rucs_pkg::PAGE_LOCAL : rucs_pkg::PAGE_FACTORY;
          end
          start_next = 1'b1;
          state_next = rucs_pkg::ST_WAIT;
        end else if (wd_kick) begin
          wd_cnt_next = '0;
        end else if (!factory && wd_en_reg) begin
          wd_cnt_next = wd_cnt_reg + 32'h1;
        end else begin
          wd_cnt_next = '0;
        end
      end
      rucs_pkg::ST_WAIT: begin
        // Let the loader drop the last done or error before watching again
        if (!done_s && !err_s) begin
          state_next = rucs_pkg::ST_LOAD;
        end
      end
      rucs_pkg::ST_FAIL: begin
        cause_next = rucs_pkg::CAUSE_LOAD_ERR;
        ev[rucs_pkg::IRQ_ERR_BIT] = 1'b1;
        page_next = local_reg ? rucs_pkg::PAGE_LOCAL : rucs_pkg::PAGE_FACTORY;
        cur_next = page_next;
        start_next = 1'b1;
        state_next = rucs_pkg::ST_WAIT;
      end
      default: begin
        state_next = rucs_pkg::ST_IDLE;
      end
    endcase
    if (state_next == rucs_pkg::ST_LOAD || state_next == rucs_pkg::ST_WAIT) begin
      if (page_next == rucs_pkg::PAGE_FACTORY && !local_reg) begin
        wd_en_next = (state_reg == rucs_pkg::ST_USER) ? wd_en_next : 1'b0;
      end
    end
  end

  always_comb begin
    imask_next = imask_reg;
    ist_next = ist_reg;
    rdata_next = rdata_reg;
    if (wr && APB_REQ.paddr == rucs_pkg::OFF_IRQ_MASK) begin
      imask_next = APB_REQ.pwdata[rucs_pkg::IRQ_W-1:0];
    end
    if (wr && APB_REQ.paddr == rucs_pkg::OFF_IRQ_STAT) begin
      ist_next = ist_reg & ~APB_REQ.pwdata[rucs_pkg::IRQ_W-1:0];
    end
    // New events win over a clear in the same cycle
    ist_next = ist_next | ev;
    if (rd) begin
      if (APB_REQ.paddr == rucs_pkg::OFF_CTRL) begin
        rdata_next = 32'h0;
        rdata_next[rucs_pkg::CTRL_PAGE_LSB +: rucs_pkg::PAGE_W] = nxt_reg;
        rdata_next[rucs_pkg::CTRL_WD_EN_BIT] = wd_en_reg;
      end else if (APB_REQ.paddr == rucs_pkg::OFF_STAT) begin
        rdata_next = 32'h0;
        rdata_next[rucs_pkg::STAT_CAUSE_LSB +: rucs_pkg::CAUSE_W] = cause_reg;
        rdata_next[rucs_pkg::STAT_PAGE_LSB +: rucs_pkg::PAGE_W] = cur_reg;
        rdata_next[rucs_pkg::STAT_FACT_BIT] = factory;
        rdata_next[rucs_pkg::STAT_USER_BIT] = (state_reg == rucs_pkg::ST_USER);
      end else if (APB_REQ.paddr == rucs_pkg::OFF_WDOG) begin
        rdata_next = wd_lim_reg;
      end else if (APB_REQ.paddr == rucs_pkg::OFF_KICK) begin
        rdata_next = wd_cnt_reg;
      end else if (APB_REQ.paddr == rucs_pkg::OFF_IRQ_STAT) begin
        rdata_next = {29'h0, ist_reg};
      end else if (APB_REQ.paddr == rucs_pkg::OFF_IRQ_MASK) begin
        rdata_next = {29'h0, imask_reg};
      end else begin
        rdata_next = rucs_pkg::APB_UNMAPPED;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      state_reg <= rucs_pkg::ST_IDLE;
      page_reg <= rucs_pkg::PAGE_FACTORY;
      cur_reg <= rucs_pkg::PAGE_FACTORY;
      nxt_reg <= rucs_pkg::PAGE_LOCAL;
      wd_en_reg <= 1'b0;
      wd_lim_reg <= rucs_pkg::WDOG_RESET;
      wd_cnt_reg <= 32'h0;
      cause_reg <= rucs_pkg::CAUSE_NONE;
      ist_reg <= '0;
      imask_reg <= '0;
      rdata_reg <= 32'h0;
      start_reg <= 1'b0;
      local_reg <= 1'b0;
    end else if (CLK_EN) begin
      state_reg <= state_next;
      page_reg <= page_next;
      cur_reg <= cur_next;
      nxt_reg <= nxt_next;
      wd_en_reg <= wd_en_next;
      wd_lim_reg <= wd_lim_next;
      wd_cnt_reg <= wd_cnt_next;
      cause_reg <= cause_next;
      ist_reg <= ist_next;
      imask_reg <= imask_next;
      rdata_reg <= rdata_next;
      start_reg <= start_next;
      local_reg <= local_next;
    end
  end

  assign LOAD_REQ.start = start_reg;
  assign LOAD_REQ.page = page_reg;
  assign USER_MODE = (state_reg == rucs_pkg::ST_USER);
  assign IRQ = |(ist_reg & imask_reg);
  assign APB_RSP.prdata = rdata_reg;
  // One wait state: data registered at the first access edge, ready on the second
  assign APB_RSP.pready = APB_REQ.psel & APB_REQ.penable & rd_seen_reg;
  assign APB_RSP.pslverr = 1'b0;

  always_ff @(posedge MCLK) begin
    if (SYS_RST) begin
      rd_seen_reg <= 1'b0;
    end else if (CLK_EN) begin
      rd_seen_reg <= APB_REQ.psel & APB_REQ.penable & ~rd_seen_reg;
    end
  end

endmodule

// ### testbench/rucs_top_sva.sv
/* Checker on the sequencer top ports.
   Assumes CLK_EN is held high and the loader answers only after a start. */
`timescale 1ns/1ps
module rucs_top_sva (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  // Mode and loader
  input wire logic LOCAL_MODE,
  input wire logic RECONF_REQ,
  input rucs_pkg::rucs_load_req_s LOAD_REQ,
  input wire logic LOAD_DONE,
  input wire logic LOAD_ERR,
  // Bus and status
  input rucs_pkg::rucs_apb_req_s APB_REQ,
  input rucs_pkg::rucs_apb_rsp_s APB_RSP,
  input wire logic USER_MODE,
  input wire logic IRQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);
  property p_por_fact;
    $fell(SYS_RST) && !LOCAL_MODE |-> ##[0:3] LOAD_REQ.start && LOAD_REQ.page == 3'h0;
  endproperty
  a_por_fact: assert property (p_por_fact) else $error("no factory load at power-up");
  property p_por_local;
    $fell(SYS_RST) && LOCAL_MODE |-> ##[0:3] LOAD_REQ.start && LOAD_REQ.page == 3'h1;
  endproperty
  a_por_local: assert property (p_por_local) else $error("no direct load in local");
  property p_err_fact;
    $rose(LOAD_ERR) && !LOCAL_MODE |-> ##[1:10] LOAD_REQ.start && LOAD_REQ.page == 3'h0;
  endproperty
  a_err_fact: assert property (p_err_fact) else $error("no fallback after error");
  property p_err_local;
    $rose(LOAD_ERR) && LOCAL_MODE |-> ##[1:10] LOAD_REQ.start && LOAD_REQ.page == 3'h1;
  endproperty
  a_err_local: assert property (p_err_local) else $error("no local reload");
  property p_done_user;
    $rose(LOAD_DONE) |-> ##[2:5] USER_MODE;
  endproperty
  a_done_user: assert property (p_done_user) else $error("no user mode after load");
  property p_leave_user;
    $fell(USER_MODE) |-> ##[0:4] LOAD_REQ.start;
  endproperty
  a_leave_user: assert property (p_leave_user) else $error("left user without load");
  property p_start_pulse;
    LOAD_REQ.start |=> !LOAD_REQ.start;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start not one cycle");
  property p_bus_wait;
    APB_REQ.psel && !APB_REQ.penable |=> !APB_RSP.pready ##1 APB_RSP.pready;
  endproperty
  a_bus_wait: assert property (p_bus_wait) else $error("bus answer timing");
endmodule

bind rucs_top rucs_top_sva chk_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(CLK_EN),
  .LOCAL_MODE(LOCAL_MODE), .RECONF_REQ(RECONF_REQ), .LOAD_REQ(LOAD_REQ),
  .LOAD_DONE(LOAD_DONE), .LOAD_ERR(LOAD_ERR), .APB_REQ(APB_REQ), .APB_RSP(APB_RSP),
  .USER_MODE(USER_MODE), .IRQ(IRQ));

// ### testbench/rucs_loader_model.sv
/* Behavioural paged configuration memory loader.
   Answers each start with done or error after a latency set by the bench. */
`timescale 1ns/1ps
module rucs_loader_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Request from the sequencer
  input rucs_pkg::rucs_load_req_s req,
  // Fault and latency control
  input wire logic [7:0] fail_pages,
  input wire logic [3:0] lat,
  // Answer levels
  output logic done,
  output logic err
);
  logic [4:0] cnt;
  logic busy, bad;
  // No stored images: any page, page zero included, answers error when its fail_pages bit is set
  always @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
      done <= 1'b0;
      err <= 1'b0;
    end else if (req.start) begin
      busy <= 1'b1;
      done <= 1'b0;
      err <= 1'b0;
      cnt <= {1'b0, lat} + 5'h1;
      bad <= fail_pages[req.page];
    end else if (busy && cnt == 5'h0) begin
      busy <= 1'b0;
      done <= !bad;
      err <= bad;
    end else if (busy) begin
      cnt <= cnt - 5'h1;
    end
  end
endmodule

// ### testbench/remote_update_config_sequencer_tb.sv
/* Self-checking bench for the sequencer with a loader model.
   Assumes bus answers arrive within a few cycles. */
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("CHECK FAILED %s exp %0h got %0h", n, e, g); end end
module remote_update_config_sequencer_tb;
  logic MCLK = 0, SYS_RST = 1, LOCAL_MODE = 0, RECONF_REQ = 0;
  rucs_pkg::rucs_apb_req_s apb_req = '0;
  rucs_pkg::rucs_apb_rsp_s apb_rsp;
  rucs_pkg::rucs_load_req_s load_req;
  logic load_done, load_err, user_mode, irq;
  logic [7:0] fail_pages = 8'h00;
  logic [3:0] lat = 4'h3;
  logic [31:0] q;
  logic [2:0] pg, pr;
  int seed = 32'hdbd0, num_errors = 0, num_checks = 0;
  initial forever #5 MCLK = ~MCLK;
  rucs_top dut_u (.MCLK(MCLK), .SYS_RST(SYS_RST), .CLK_EN(1'b1), .LOCAL_MODE(LOCAL_MODE),
    .RECONF_REQ(RECONF_REQ), .LOAD_REQ(load_req), .LOAD_DONE(load_done),
    .LOAD_ERR(load_err), .APB_REQ(apb_req), .APB_RSP(apb_rsp), .USER_MODE(user_mode),
    .IRQ(irq));
  rucs_loader_model mem_u (.clk(MCLK), .rst(SYS_RST), .req(load_req),
    .fail_pages(fail_pages), .lat(lat), .done(load_done), .err(load_err));
  task automatic results();
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    @(posedge MCLK);
    apb_req <= '{1'b1, 1'b0, w, a, d};
    lat <= 4'($random(seed));
    @(posedge MCLK);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge MCLK);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 20);
    q = apb_rsp.prdata;
    apb_req <= '0;
    if (n >= 20) begin
      num_errors++;
      results();
    end
  endtask
  // Bounded wait for a start pulse or for user mode, as seen at the clock edge
  task automatic wait_for(bit usr);
    int n;
    n = 0;
    do begin
      @(posedge MCLK);
      n++;
    end while ((usr ? user_mode : load_req.start) !== 1'b1 && n < 500);
    pg = load_req.page;
    if (n >= 500) begin
      num_errors++;
      results();
    end
  endtask
  function automatic logic [31:0] fst(logic [1:0] c);
    fst = (32'h1 << rucs_pkg::STAT_USER_BIT) | (32'h1 << rucs_pkg::STAT_FACT_BIT) | 32'(c);
  endfunction
  task automatic boot(logic [2:0] p, logic wd);
    apb(1'b1, rucs_pkg::OFF_CTRL, 32'h100 | (32'(wd) << 4) | 32'(p));
    wait_for(1'b0);
    `CHK("page", p, pg)
  endtask
  task automatic stat(logic [1:0] c);
    wait_for(1'b1);
    apb(1'b0, rucs_pkg::OFF_STAT, 32'h0);
    `CHK("status", fst(c), q)
  endtask
  initial begin
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wait_for(1'b0);
    `CHK("por page", 3'h0, pg)
    stat(rucs_pkg::CAUSE_NONE);
    apb(1'b0, rucs_pkg::OFF_KICK, 32'h0);
    `CHK("wd count", 32'h0, q)
    apb(1'b0, 12'h020, 32'h0);
    `CHK("unmapped", rucs_pkg::APB_UNMAPPED, q)
    apb(1'b1, rucs_pkg::OFF_WDOG, 32'd40);
    for (int p = 1; p < 8; p++) begin
      boot(3'(p), 1'b0);
      wait_for(1'b1);
      // Application write to control is refused: page and watchdog enable stay
      apb(1'b1, rucs_pkg::OFF_CTRL, 32'h017);
      repeat (60) @(posedge MCLK);
      `CHK("app stays", 1'b1, user_mode)
      apb(1'b0, rucs_pkg::OFF_CTRL, 32'h0);
      `CHK("app ctrl", 32'(p), q)
      apb(1'b0, rucs_pkg::OFF_STAT, 32'h0);
      `CHK("app stat", {3'h4, 3'(p)}, q[9:4])
      RECONF_REQ <= 1'b1;
      wait_for(1'b0);
      RECONF_REQ <= 1'b0;
      `CHK("reload", 3'h0, pg)
      stat(rucs_pkg::CAUSE_REQ);
    end
    pr = 3'(1 + $unsigned($random(seed)) % 7);
    fail_pages <= 8'h1 << pr;
    boot(pr, 1'b0);
    wait_for(1'b0);
    `CHK("err page", 3'h0, pg)
    fail_pages <= 8'h00;
    stat(rucs_pkg::CAUSE_LOAD_ERR);
    boot(pr, 1'b1);
    wait_for(1'b1);
    repeat (5) begin
      repeat (10) @(posedge MCLK);
      apb(1'b1, rucs_pkg::OFF_KICK, 32'h0);
    end
    `CHK("kicked", 1'b1, user_mode)
    wait_for(1'b0);
    `CHK("wd page", 3'h0, pg)
    stat(rucs_pkg::CAUSE_WDOG);
    apb(1'b1, rucs_pkg::OFF_IRQ_MASK, 32'h4);
    @(posedge MCLK);
    #1;
    `CHK("irq on", 1'b1, irq)
    apb(1'b1, rucs_pkg::OFF_IRQ_STAT, 32'h4);
    @(posedge MCLK);
    #1;
    `CHK("irq off", 1'b0, irq)
    apb(1'b0, rucs_pkg::OFF_IRQ_STAT, 32'h0);
    `CHK("irq stat", 32'h3, q)
    LOCAL_MODE <= 1'b1;
    SYS_RST <= 1'b1;
    fail_pages <= 8'h02;
    repeat (10) @(posedge MCLK);
    SYS_RST <= 1'b0;
    wait_for(1'b0);
    `CHK("local page", rucs_pkg::PAGE_LOCAL, pg)
    fail_pages <= 8'h00;
    wait_for(1'b0);
    `CHK("local retry", rucs_pkg::PAGE_LOCAL, pg)
    wait_for(1'b1);
    `CHK("local user", 1'b1, user_mode)
    results();
  end
endmodule
